// File: rx_lane_sync_and_alignment.sv
// How it works
// - K28.1, K28.5, K28.7 count as commas
// - comma pattern 0011111 or 1100000 delimits groups
// - per lane 32 data plus 4 K flags
// - alignment character is passed on, not stripped
// - fifo bypass gives each lane its clock
// - decoder bypass passes 40-bit raw, no alignment
// - fabric word carries four code groups
// - per-lane hysteresis sync, synced low until acquired
// - four idle ordered sets reach first acquired
// - back-to-back commas need five in total
// - comma event needs valid, good disparity, comma
// - good and bad code-group events flagged
// - comma timer restarts on comma, expiry drops sync
// - pairs, quads or all eight lanes grouped
// - four-channel variant: upper pairs or all four
// - disabling a lane leaves its group intact
// - each group flags fifo overflow
// - down counter zero before all aligned: out-of-sync
// - mode codes 00 none, 10 pair, 01 quad, 11 eight
module rx_lane_sync_and_alignment #(
  parameter bit FOUR_CHANNEL = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [319:0] lane_raw,
  input wire logic [255:0] lane_data,
  input wire logic [31:0] lane_kflag,
  input wire logic [31:0] lane_cg_valid,
  input wire logic [31:0] lane_disp_ok,
  input wire logic [7:0] lane_rec_clk,
  output logic [255:0] rx_data,
  output logic [31:0] rx_kflag,
  output logic [319:0] rx_raw,
  output logic [7:0] rx_valid,
  output logic [31:0] rx_comma,
  output logic [31:0] good_group_seen,
  output logic [31:0] bad_group_seen,
  output logic [7:0] lane_synced,
  output logic [7:0] rx_lane_clk
);

  localparam int NL = rx_align_pkg::NUM_LANES;
  localparam int NG = rx_align_pkg::NUM_GROUPS;

  // ****************************************
  // registers and bus slave
  // ****************************************
  logic [31:0] mode_reg;
  logic [31:0] enable_reg;
  logic [31:0] resync_reg;
  logic [31:0] status_word;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic do_write;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= rx_align_pkg::MODE_RESET;
      enable_reg <= rx_align_pkg::ENABLE_RESET;
      resync_reg <= rx_align_pkg::RESYNC_RESET;
      bvalid <= 1'b0;
      bresp <= rx_align_pkg::RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= rx_align_pkg::RESP_OKAY;
        case (aw_addr[7:0])
          rx_align_pkg::REG_MODE: mode_reg <= merge(mode_reg, w_data, w_strb) & 32'h0000_ffff;
          rx_align_pkg::REG_ENABLE: enable_reg <= merge(enable_reg, w_data, w_strb) & 32'h0000_03ff;
          rx_align_pkg::REG_RESYNC: resync_reg <= merge(resync_reg, w_data, w_strb) & 32'h0000_ff7f;
          default: bresp <= rx_align_pkg::RESP_SLVERR;
        endcase
        if (aw_addr[31:8] != 24'h00_0000) begin
          bresp <= rx_align_pkg::RESP_SLVERR;
        end
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rx_align_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= rx_align_pkg::RESP_OKAY;
      case (araddr[7:0])
        rx_align_pkg::REG_MODE: rdata <= mode_reg;
        rx_align_pkg::REG_ENABLE: rdata <= enable_reg;
        rx_align_pkg::REG_RESYNC: rdata <= resync_reg;
        rx_align_pkg::REG_STATUS: rdata <= status_word;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= rx_align_pkg::RESP_SLVERR;
        end
      endcase
      if (araddr[31:8] != 24'h00_0000) begin
        rdata <= 32'h0000_0000;
        rresp <= rx_align_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // code-group events
  // ****************************************
  logic dec_bypass;
  logic fifo_bypass;
  logic [31:0] comma_ev;
  logic [31:0] good_ev;
  logic [31:0] bad_ev;
  logic [7:0] align_char;

  assign dec_bypass = enable_reg[rx_align_pkg::DEC_BYPASS_BIT];
  assign fifo_bypass = enable_reg[rx_align_pkg::FIFO_BYPASS_BIT];

  always_comb begin
    logic [9:0] cg;
    logic [7:0] ch;
    cg = 10'h000;
    ch = 8'h00;
    for (int n = 0; n < NL * rx_align_pkg::CG_PER_WORD; n++) begin
      cg = lane_raw[n*rx_align_pkg::CG_BITS +: 10];
      ch = lane_data[n*8 +: 8];
      good_ev[n] = lane_cg_valid[n] && lane_disp_ok[n];
      bad_ev[n] = !lane_cg_valid[n];
      comma_ev[n] = good_ev[n] && lane_kflag[n]
        && (ch == rx_align_pkg::K28_1 || ch == rx_align_pkg::K28_5 || ch == rx_align_pkg::K28_7)
        && (cg[6:0] == rx_align_pkg::COMMA_POS || cg[6:0] == rx_align_pkg::COMMA_NEG);
    end
    for (int i = 0; i < NL; i++) begin
      align_char[i] = lane_kflag[i*4] && (lane_data[i*32 +: 8] == rx_align_pkg::K28_3
        || lane_data[i*32 +: 8] == rx_align_pkg::K28_5);
    end
  end

  // ****************************************
  // lane synchronization machines
  // ****************************************
  rx_align_pkg::sync_state_t sync_st [NL];
  rx_align_pkg::sync_state_t next_sync_st [NL];
  logic [7:0] gap;
  logic [7:0] next_gap;
  logic [1:0] good_cnt [NL];
  logic [1:0] next_good_cnt [NL];
  logic [9:0] comma_timer [NL];
  logic [7:0] no_comma;
  logic [7:0] word_comma;

  always_comb begin
    rx_align_pkg::sync_state_t st;
    logic gp;
    logic [1:0] gc;
    logic c;
    logic g;
    logic b;
    st = rx_align_pkg::state_unsynced;
    gp = 1'b0;
    gc = 2'h0;
    c = 1'b0;
    g = 1'b0;
    b = 1'b0;
    for (int i = 0; i < NL; i++) begin
      st = sync_st[i];
      gp = gap[i];
      gc = good_cnt[i];
      word_comma[i] = |comma_ev[i*4 +: 4];
      no_comma[i] = comma_timer[i] == 10'(rx_align_pkg::COMMA_TIMEOUT_CYCLES - 1);
      for (int k = 0; k < rx_align_pkg::CG_PER_WORD; k++) begin
        c = comma_ev[i*4+k];
        g = good_ev[i*4+k];
        b = bad_ev[i*4+k];
        case (st)
          rx_align_pkg::state_unsynced: begin
            if (c) begin
              st = rx_align_pkg::state_comma_1;
              gp = 1'b0;
            end
          end
          rx_align_pkg::state_comma_1: begin
            if (b) begin
              st = rx_align_pkg::state_unsynced;
            end else if (c && gp) begin
              st = rx_align_pkg::state_comma_2;
            end else if (g) begin
              gp = 1'b1;
            end
          end
          rx_align_pkg::state_comma_2: begin
            if (b) begin
              st = rx_align_pkg::state_unsynced;
            end else if (c) begin
              st = rx_align_pkg::state_comma_3;
            end
          end
          rx_align_pkg::state_comma_3: begin
            if (b) begin
              st = rx_align_pkg::state_unsynced;
            end else if (c) begin
              st = rx_align_pkg::state_acq_1;
              gc = 2'h0;
            end
          end
          rx_align_pkg::state_acq_1: begin
            if (b) begin
              st = rx_align_pkg::state_acq_2;
              gc = 2'h0;
            end
          end
          default: begin
            if (b) begin
              gc = 2'h0;
              case (st)
                rx_align_pkg::state_acq_2: st = rx_align_pkg::state_acq_3;
                rx_align_pkg::state_acq_3: st = rx_align_pkg::state_acq_4;
                default: st = rx_align_pkg::state_unsynced;
              endcase
            end else if (g && gc == rx_align_pkg::GOOD_RUN_LAST) begin
              gc = 2'h0;
              case (st)
                rx_align_pkg::state_acq_4: st = rx_align_pkg::state_acq_3;
                rx_align_pkg::state_acq_3: st = rx_align_pkg::state_acq_2;
                default: st = rx_align_pkg::state_acq_1;
              endcase
            end else if (g) begin
              gc = gc + 2'h1;
            end
          end
        endcase
      end
      if (no_comma[i] && !word_comma[i]) begin
        st = rx_align_pkg::state_unsynced;
      end
      next_sync_st[i] = st;
      next_gap[i] = gp;
      next_good_cnt[i] = gc;
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < NL; i++) begin
      if (!aresetn) begin
        sync_st[i] <= rx_align_pkg::state_unsynced;
        gap[i] <= 1'b0;
        good_cnt[i] <= 2'h0;
        comma_timer[i] <= 10'h000;
        lane_synced[i] <= 1'b0;
      end else begin
        sync_st[i] <= next_sync_st[i];
        gap[i] <= next_gap[i];
        good_cnt[i] <= next_good_cnt[i];
        comma_timer[i] <= (word_comma[i] || no_comma[i]) ? 10'h000 : comma_timer[i] + 10'h001;
        lane_synced[i] <= !next_sync_st[i][0] && !next_sync_st[i][1]
          && !next_sync_st[i][2] && !next_sync_st[i][3];
      end
    end
  end

  // ****************************************
  // group membership
  // ****************************************
  logic [NL-1:0] member [NG];
  logic [NL-1:0] in_group;

  always_comb begin
    logic [1:0] m;
    m = rx_align_pkg::MODE_NONE;
    for (int g = 0; g < NG; g++) begin
      member[g] = '0;
    end
    for (int i = 0; i < NL; i++) begin
      m = mode_reg[i*2 +: 2];
      if (FOUR_CHANNEL && (i % 4 < 2 || m == rx_align_pkg::MODE_QUAD)) begin
        m = rx_align_pkg::MODE_NONE;
      end
      if (dec_bypass || fifo_bypass || !enable_reg[i]) begin
        m = rx_align_pkg::MODE_NONE;
      end
      case (m)
        rx_align_pkg::MODE_PAIR: member[i/2][i] = 1'b1;
        rx_align_pkg::MODE_QUAD: member[rx_align_pkg::GRP_QUAD_BASE + i/4][i] = 1'b1;
        rx_align_pkg::MODE_EIGHT: member[rx_align_pkg::GRP_EIGHT][i] = 1'b1;
        default: ;
      endcase
    end
    for (int i = 0; i < NL; i++) begin
      in_group[i] = 1'b0;
      for (int g = 0; g < NG; g++) begin
        in_group[i] = in_group[i] | member[g][i];
      end
    end
  end

  // ****************************************
  // resync edges
  // ****************************************
  logic [15:0] resync_q;
  logic [NG-1:0] grp_rise;
  logic [NL-1:0] lane_rise;
  logic [NL-1:0] lane_clear;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resync_q <= rx_align_pkg::RESYNC_RESET[15:0];
    end else begin
      resync_q <= resync_reg[15:0];
    end
  end

  always_comb begin
    grp_rise = resync_reg[NG-1:0] & ~resync_q[NG-1:0];
    lane_rise = resync_reg[rx_align_pkg::RESYNC_LANE_LSB +: NL] & ~resync_q[rx_align_pkg::RESYNC_LANE_LSB +: NL];
    for (int i = 0; i < NL; i++) begin
      lane_clear[i] = lane_rise[i] || !in_group[i];
      for (int g = 0; g < NG; g++) begin
        lane_clear[i] = lane_clear[i] || (grp_rise[g] && member[g][i]);
      end
    end
  end

  // ****************************************
  // alignment fifos
  // ****************************************
  logic [35:0] fifo_mem [NL][rx_align_pkg::FIFO_DEPTH];
  logic [2:0] wr_ptr [NL];
  logic [2:0] rd_ptr [NL];
  logic [3:0] fill [NL];
  logic [NL-1:0] found;
  logic [NL-1:0] lane_go;
  logic [NL-1:0] lane_ovf;
  logic [NG-1:0] released;
  logic [NG-1:0] all_found;
  logic [NG-1:0] any_found;
  logic [5:0] down_cnt [NG];
  logic [NG-1:0] group_fifo_overflow;
  logic [NG-1:0] group_out_of_sync;

  always_comb begin
    for (int g = 0; g < NG; g++) begin
      all_found[g] = |member[g] && ((found & member[g]) == member[g]);
      any_found[g] = |(found & member[g]);
    end
    for (int i = 0; i < NL; i++) begin
      lane_go[i] = 1'b0;
      lane_ovf[i] = found[i] && !lane_go[i] && fill[i] == rx_align_pkg::FIFO_FULL;
      for (int g = 0; g < NG; g++) begin
        lane_go[i] = lane_go[i] | (released[g] & member[g][i]);
      end
      lane_ovf[i] = found[i] && !lane_go[i] && fill[i] == rx_align_pkg::FIFO_FULL;
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < NL; i++) begin
      if (!aresetn || lane_clear[i]) begin
        wr_ptr[i] <= 3'h0;
        rd_ptr[i] <= 3'h0;
        fill[i] <= 4'h0;
        found[i] <= 1'b0;
      end else if (!found[i]) begin
        if (align_char[i]) begin
          fifo_mem[i][wr_ptr[i]] <= {lane_kflag[i*4 +: 4], lane_data[i*32 +: 32]};
          rd_ptr[i] <= wr_ptr[i];
          wr_ptr[i] <= wr_ptr[i] + 3'h1;
          fill[i] <= 4'h1;
          found[i] <= 1'b1;
        end
      end else if (lane_go[i]) begin
        fifo_mem[i][wr_ptr[i]] <= {lane_kflag[i*4 +: 4], lane_data[i*32 +: 32]};
        wr_ptr[i] <= wr_ptr[i] + 3'h1;
        rd_ptr[i] <= rd_ptr[i] + 3'h1;
      end else if (!lane_ovf[i]) begin
        fifo_mem[i][wr_ptr[i]] <= {lane_kflag[i*4 +: 4], lane_data[i*32 +: 32]};
        wr_ptr[i] <= wr_ptr[i] + 3'h1;
        fill[i] <= fill[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int g = 0; g < NG; g++) begin
      if (!aresetn || grp_rise[g]) begin
        released[g] <= 1'b0;
        down_cnt[g] <= 6'(rx_align_pkg::ALIGN_WINDOW_CYCLES);
        group_fifo_overflow[g] <= 1'b0;
        group_out_of_sync[g] <= 1'b0;
      end else begin
        if (!(|member[g])) begin
          released[g] <= 1'b0;
        end else if (all_found[g]) begin
          released[g] <= 1'b1;
        end
        if (!released[g] && any_found[g] && down_cnt[g] != 6'h00) begin
          down_cnt[g] <= down_cnt[g] - 6'h01;
        end
        if (!released[g] && down_cnt[g] == 6'h00 && !all_found[g]) begin
          group_out_of_sync[g] <= 1'b1;
        end
        if (|(lane_ovf & member[g])) begin
          group_fifo_overflow[g] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // fabric outputs
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data <= '0;
      rx_kflag <= '0;
      rx_raw <= '0;
      rx_valid <= '0;
      rx_comma <= '0;
      good_group_seen <= '0;
      bad_group_seen <= '0;
    end else begin
      rx_raw <= lane_raw;
      rx_comma <= comma_ev;
      good_group_seen <= good_ev;
      bad_group_seen <= bad_ev;
      for (int i = 0; i < NL; i++) begin
        if (in_group[i]) begin
          {rx_kflag[i*4 +: 4], rx_data[i*32 +: 32]} <= fifo_mem[i][rd_ptr[i]];
          rx_valid[i] <= lane_go[i];
        end else begin
          rx_data[i*32 +: 32] <= lane_data[i*32 +: 32];
          rx_kflag[i*4 +: 4] <= lane_kflag[i*4 +: 4];
          rx_valid[i] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      rx_lane_clk[i] = fifo_bypass ? lane_rec_clk[i] : aclk;
    end
  end

  assign status_word = {1'b0, released, lane_synced, 1'b0, group_out_of_sync, 1'b0, group_fifo_overflow};

endmodule // rx_lane_sync_and_alignment

// File: rx_align_pkg.sv
package rx_align_pkg;

  // ****************************************
  // lane and word geometry
  // ****************************************
  localparam int NUM_LANES = 8;
  localparam int CG_PER_WORD = 4;
  localparam int CG_BITS = 10;
  localparam int RAW_BITS = 40;
  localparam int NUM_GROUPS = 7;
  localparam int GRP_QUAD_BASE = 4;
  localparam int GRP_EIGHT = 6;

  // ****************************************
  // group mode codes, per lane
  // ****************************************
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_PAIR = 2'h2;
  localparam logic [1:0] MODE_QUAD = 2'h1;
  localparam logic [1:0] MODE_EIGHT = 2'h3;

  // ****************************************
  // special characters
  // ****************************************
  localparam logic [7:0] K28_1 = 8'h3c;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_7 = 8'hfc;
  localparam logic [6:0] COMMA_POS = 7'h7c;
  localparam logic [6:0] COMMA_NEG = 7'h03;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int COMMA_TIMEOUT_NS = 10000;
  localparam int COMMA_TIMEOUT_CYCLES = COMMA_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int ALIGN_WINDOW_NS = 320;
  localparam int ALIGN_WINDOW_CYCLES = ALIGN_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [1:0] GOOD_RUN_LAST = 2'h3;

  // ****************************************
  // alignment fifo
  // ****************************************
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam logic [3:0] FIFO_FULL = 4'h8;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_ENABLE = 8'h04;
  localparam logic [7:0] REG_RESYNC = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_00ff;
  localparam logic [31:0] RESYNC_RESET = 32'h0000_ff7f;
  localparam int DEC_BYPASS_BIT = 8;
  localparam int FIFO_BYPASS_BIT = 9;
  localparam int RESYNC_LANE_LSB = 8;
  localparam int STAT_OOS_LSB = 8;
  localparam int STAT_SYNC_LSB = 16;
  localparam int STAT_ALIGNED_LSB = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [7:0] {
    state_unsynced = 8'h01,
    state_comma_1 = 8'h02,
    state_comma_2 = 8'h04,
    state_comma_3 = 8'h08,
    state_acq_1 = 8'h10,
    state_acq_2 = 8'h20,
    state_acq_3 = 8'h40,
    state_acq_4 = 8'h80
  } sync_state_t;

endpackage

// File: rx_lane_sync_and_alignment_asserts.sv
module rx_lane_sync_and_alignment_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [319:0] lane_raw,
  input wire logic [31:0] lane_cg_valid,
  input wire logic [31:0] lane_disp_ok,
  input wire logic [319:0] rx_raw,
  input wire logic [31:0] rx_comma,
  input wire logic [31:0] good_group_seen,
  input wire logic [31:0] bad_group_seen,
  input wire logic [7:0] lane_synced
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // comma quiet time and comma count on lane 0
  // ********
  logic [10:0] quiet;
  logic [3:0] commas;
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_comma[3:0] != 4'h0) begin
      quiet <= 11'h000;
    end else if (quiet != 11'h7ff) begin
      quiet <= quiet + 11'h001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commas <= 4'h0;
    end else if (commas < 4'h8) begin
      commas <= commas + 4'($countones(rx_comma[3:0]));
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bad_code_a: assert property ($past(aresetn) && !$past(lane_cg_valid[0]) |-> bad_group_seen[0])
    else $error("bad group event missing");
  good_code_a: assert property (good_group_seen[0] |-> $past(lane_cg_valid[0] && lane_disp_ok[0]))
    else $error("good group event without cause");
  comma_valid_a: assert property (rx_comma[0] |-> $past(lane_cg_valid[0] && lane_disp_ok[0]))
    else $error("comma event on bad group");
  raw_copy_a: assert property ($past(aresetn) |-> rx_raw == $past(lane_raw))
    else $error("raw path not a one cycle copy");
  comma_timer_a: assert property (quiet > 11'h3f2 |-> !lane_synced[0])
    else $error("sync kept without commas");
  sync_hold_a: assert property ($past(aresetn) && commas + 4'($countones(rx_comma[3:0])) < 4'h4
    |-> !lane_synced[0])
    else $error("sync before enough commas");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  cover property ($rose(lane_synced[0]));
  cover property (bvalid && bready && bresp == 2'h2);
  cover property (quiet == 11'h3f3);
endmodule // rx_lane_sync_and_alignment_asserts

bind rx_lane_sync_and_alignment rx_lane_sync_and_alignment_asserts u_rx_lane_sync_and_alignment_asserts (.*);

// File: rx_fabric_sink.sv
module rx_fabric_sink (
  input wire logic aclk,
  input wire logic arm,
  input wire logic [7:0] rx_valid,
  input wire logic [255:0] rx_data,
  output logic [255:0] first_word,
  output logic [7:0][15:0] first_at
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] now = 16'h0000;
  logic [7:0] got;
  // fabric takes each lane's first valid word and its cycle
  always_ff @(posedge aclk) begin
    now <= now + 16'h0001;
    for (int i = 0; i < 8; i++) begin
      if (arm) begin
        got[i] <= 1'b0;
      end else if (rx_valid[i] && !got[i]) begin
        got[i] <= 1'b1;
        first_word[i*32 +: 32] <= rx_data[i*32 +: 32];
        first_at[i] <= now;
      end
    end
  end
endmodule // rx_fabric_sink

// File: rx_lane_sync_and_alignment_bench.sv
module rx_lane_sync_and_alignment_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, arm;
  logic [31:0] awaddr, wdata, araddr, rdata, q, lane_kflag, lane_cg_valid, lane_disp_ok, rx_kflag, rx_comma;
  logic [31:0] good_group_seen, bad_group_seen;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [319:0] lane_raw, rx_raw;
  logic [255:0] lane_data, rx_data, first_word;
  logic [7:0] lane_rec_clk, rx_valid, lane_synced, rx_lane_clk;
  logic [7:0][15:0] first_at;
  logic [7:0] kch [4] = '{rx_align_pkg::K28_1, rx_align_pkg::K28_5, rx_align_pkg::K28_7, rx_align_pkg::K28_3};
  localparam logic [31:0] idle_w = 32'hb5b5b5b5;
  localparam logic [31:0] os_w = 32'hb5b595bc;
  localparam logic [31:0] align_w = 32'hb5b5b57c;
  int errors = 0;
  int checks = 0;
  rx_lane_sync_and_alignment u_rx_lane_sync_and_alignment (.*);
  rx_fabric_sink u_rx_fabric_sink (.aclk(aclk), .arm(arm), .rx_valid(rx_valid), .rx_data(rx_data),
    .first_word(first_word), .first_at(first_at));
  always #5 aclk = ~aclk;
  // ********
  // access tasks
  // ********
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tr, done;
    @(posedge aclk);
    awaddr <= {24'h000000, a};
    araddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      done = wr ? bvalid : rvalid;
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
    end while (!done);
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic resync();
    bus(1'b1, rx_align_pkg::REG_RESYNC, 32'h0000ff7e);
    bus(1'b1, rx_align_pkg::REG_RESYNC, 32'h0000ff7f);
  endtask
  task automatic send(input logic [255:0] d, input logic [31:0] k, input int n);
    @(posedge aclk);
    lane_data <= d;
    lane_kflag <= k;
    repeat (n - 1) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    stop_test();
  end
  // ********
  // tests
  // ********
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, arm} = '0;
    {awaddr, wdata, araddr, lane_data, lane_kflag} = '0;
    wstrb = 4'hf;
    lane_cg_valid = '1;
    lane_disp_ok = '1;
    lane_raw = {32{10'h17c}};
    lane_rec_clk = 8'ha5;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, rx_align_pkg::REG_ENABLE, 32'h0);
    check("enable", q, rx_align_pkg::ENABLE_RESET);
    bus(1'b0, rx_align_pkg::REG_RESYNC, 32'h0);
    check("resync", q, rx_align_pkg::RESYNC_RESET);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", {30'h0, r}, {30'h0, rx_align_pkg::RESP_SLVERR});
    bus(1'b1, rx_align_pkg::REG_STATUS, 32'h1);
    check("ro", {30'h0, r}, {30'h0, rx_align_pkg::RESP_SLVERR});
    $display("test regs done");
    check("synced", {24'h0, lane_synced}, 32'h0);
    send({8{32'hbcbcbcbc}}, {8{4'hf}}, 1);
    send({8{os_w}}, {8{4'h1}}, 1);
    send({8{idle_w}}, 32'h0, 4);
    check("synced", {24'h0, lane_synced}, 32'hff);
    send({8{idle_w}}, 32'h0, 1050);
    check("synced", {24'h0, lane_synced}, 32'h0);
    send({8{os_w}}, {8{4'h1}}, 3);
    send({8{idle_w}}, 32'h0, 3);
    check("synced", {24'h0, lane_synced}, 32'h0);
    send({8{os_w}}, {8{4'h1}}, 1);
    send({8{idle_w}}, 32'h0, 4);
    check("synced", {24'h0, lane_synced}, 32'hff);
    $display("test sync done");
    for (int i = 0; i < 4; i++) begin
      send({8{24'hb5b5b5, kch[i]}}, {8{4'h1}}, 2);
      check("comma", {31'h0, rx_comma[0]}, {31'h0, i < 3});
      check("data", rx_data[95:64], {24'hb5b5b5, kch[i]});
    end
    @(posedge aclk);
    lane_cg_valid <= {8{4'hd}};
    lane_disp_ok <= {8{4'he}};
    send({8{32'hb5b5b5bc}}, {8{4'h1}}, 2);
    check("comma", {28'h0, rx_comma[3:0]}, 32'h0);
    check("good", {28'h0, good_group_seen[3:0]}, 32'hc);
    check("bad", {28'h0, bad_group_seen[3:0]}, 32'h2);
    @(posedge aclk);
    lane_cg_valid <= '1;
    lane_disp_ok <= '1;
    lane_data <= {8{idle_w}};
    lane_kflag <= '0;
    $display("test events done");
    #1;
    check("lclk", {24'h0, rx_lane_clk}, 32'hff);
    bus(1'b1, rx_align_pkg::REG_ENABLE, 32'h000003ff);
    check("lclk", {24'h0, rx_lane_clk}, 32'ha5);
    bus(1'b1, rx_align_pkg::REG_ENABLE, 32'h000000ff);
    bus(1'b1, rx_align_pkg::REG_MODE, 32'h0000000a);
    resync();
    @(posedge aclk);
    arm <= 1'b1;
    @(posedge aclk);
    arm <= 1'b0;
    send({{7{idle_w}}, align_w}, 32'h1, 2);
    send({{6{idle_w}}, align_w, idle_w}, 32'h10, 1);
    send({8{idle_w}}, 32'h0, 8);
    check("first0", first_word[31:0], align_w);
    check("first1", first_word[63:32], align_w);
    check("when", {16'h0, first_at[0]}, {16'h0, first_at[1]});
    check("free", {31'h0, rx_valid[2]}, 32'h1);
    bus(1'b1, rx_align_pkg::REG_ENABLE, 32'h000000fd);
    send({8{idle_w}}, 32'h0, 4);
    check("keep", {31'h0, rx_valid[0]}, 32'h1);
    bus(1'b0, rx_align_pkg::REG_STATUS, 32'h0);
    check("stat", q & 32'h00000101, 32'h0);
    $display("test group done");
    bus(1'b1, rx_align_pkg::REG_ENABLE, 32'h000000ff);
    resync();
    send({{7{idle_w}}, align_w}, 32'h1, 1);
    send({8{idle_w}}, 32'h0, 40);
    bus(1'b0, rx_align_pkg::REG_STATUS, 32'h0);
    check("group_fifo_overflow", q & 32'h1, 32'h1);
    check("oos", q & 32'h100, 32'h100);
    resync();
    bus(1'b0, rx_align_pkg::REG_STATUS, 32'h0);
    check("clear", q & 32'h101, 32'h0);
    $display("test status done");
    stop_test();
  end
endmodule // rx_lane_sync_and_alignment_bench
